// ==== hw/drive_setpoint_and_ramp_select.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "setpoint_defines.svh"

// Notes on behaviour
// - Source select 00 takes pot, 01 analog input, 02 stored setpoint.
// - Source select resets to analog; inputs are 0-10 V or 4-20 mA.
// - Without fixed-frequency selects, the entry value shows the current setpoint.
// - With fixed-frequency selects, the entry value shows the selected stage frequency.
// - An entry confirmed by enter under fixed selects goes into that stage.
// - Arrow keys edit, enter confirms, the value lands in the stored setpoint.
// - Entry writes are taken even while write protection is set.
// - Stored setpoint spans 0.5-360 Hz, resets to zero, used only under 02.
// - Presented setpoint has one format for every source, in 0.1 Hz steps.
// - A start ramps output up to the setpoint; 0 to end frequency takes the acceleration time.
// - A stop ramps output down to zero within the deceleration time.
// - Ramp times use 0.1 s steps below 1000 s, 1 s steps above.
// - Direction 00 runs clockwise on a keypad start, 01 anticlockwise; default 00.
// - Start select 01 uses run inputs, 02 keypad start key; default 01.
module drive_setpoint_and_ramp_select #(
   parameter int unsigned RAMP_UNIT_CYCLES = `RAMP_UNIT_CYCLES
) (
   // Clock and reset.
   input  wire logic                  pclk,
   input  wire logic                  presetn,
   // APB slave.
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [7:0]            paddr,
   input  wire logic [31:0]           pwdata,
   output logic      [31:0]           prdata,
   output logic                       pready,
   output logic                       pslverr,
   // Operator panel and control pins, asynchronous to pclk.
   input  wire setpoint_pkg::panel_t  panel_in,
   // Output frequency path.
   output logic      [11:0]           out_freq,
   output logic                       rotation_ccw,
   output logic                       running
);

   setpoint_pkg::main_state_t st_q;
   setpoint_pkg::main_state_t st_d;
   setpoint_pkg::panel_t      pin;
   logic                      up_edge;
   logic                      down_edge;
   logic                      enter_edge;
   logic                      start_edge;
   logic                      stop_edge;
   logic [3:0]                ff_sel;
   logic [11:0]               analog;
   logic [11:0]               base;
   logic [11:0]               setpoint;
   logic [11:0]               edit_base;
   logic [11:0]               target;
   logic                      cw_cmd;
   logic                      ccw_cmd;
   logic                      run_on;
   logic                      stopped;
   logic                      wr_acc;
   logic                      rd_setup;
   logic                      mapped;
   logic [31:0]               rd_val;

   // Clamp a written frequency into the legal setpoint span.
   function automatic logic [11:0] clamp_freq(input logic [31:0] v);
      logic [11:0] r;
      if (v < 32'(`FREQ_MIN)) begin
         r = `FREQ_MIN;
      end else if (v > 32'(`FREQ_MAX)) begin
         r = `FREQ_MAX;
      end else begin
         r = v[11:0];
      end
      return r;
   endfunction

   // Clamp a ramp time and drop the tenths in the coarse range.
   function automatic logic [14:0] quant_ramp(input logic [31:0] v);
      logic [14:0] r;
      if (v < 32'(`RAMP_MIN)) begin
         r = `RAMP_MIN;
      end else if (v > 32'(`RAMP_MAX)) begin
         r = `RAMP_MAX;
      end else begin
         r = v[14:0];
      end
      if (r >= `RAMP_COARSE) begin
         r = r - (r % `RAMP_COARSE_STEP);
      end
      return r;
   endfunction

   // Keys are edge-detected by comparing the second synchroniser stage with the third.
   assign pin        = st_q.s2;
   assign up_edge    = pin.key_up & ~st_q.s3.key_up;
   assign down_edge  = pin.key_down & ~st_q.s3.key_down;
   assign enter_edge = pin.key_enter & ~st_q.s3.key_enter;
   assign start_edge = pin.key_start & ~st_q.s3.key_start;
   assign stop_edge  = pin.key_stop & ~st_q.s3.key_stop;
   assign ff_sel     = pin.fixed_freq_stage_select;
   assign stopped    = (st_q.st == setpoint_pkg::ST_STOPPED);

   // Setpoint selection; every source already arrives in 0.1 Hz units, so
   // the presented value needs no per-source formatting.
   always_comb begin
      analog = st_q.ctrl.use_current_input ? pin.current_setpoint_input : pin.voltage_setpoint_input;
      case (st_q.ctrl.setpoint_source_select)
         `SRC_POT: begin
            base = pin.keypad_pot_input;
         end
         `SRC_ANALOG: begin
            base = analog;
         end
         default: begin
            base = st_q.stored_setpoint_freq;
         end
      endcase
      setpoint  = (ff_sel != 4'h0) ? st_q.stage[ff_sel] : base;
      edit_base = st_q.dirty ? st_q.edit : setpoint;
   end

   // Start commands; both run inputs at once count as no command.
   always_comb begin
      if (st_q.ctrl.start_source_select == `START_KEYPAD) begin
         cw_cmd  = st_q.kp_run & (st_q.ctrl.rotation_direction_select == `DIR_CW);
         ccw_cmd = st_q.kp_run & (st_q.ctrl.rotation_direction_select != `DIR_CW);
      end else begin
         cw_cmd  = pin.run_forward_input & ~pin.run_reverse_input;
         ccw_cmd = pin.run_reverse_input & ~pin.run_forward_input;
      end
      run_on = (st_q.st == setpoint_pkg::ST_RUN_CW && cw_cmd) || (st_q.st == setpoint_pkg::ST_RUN_CCW && ccw_cmd);
      target = run_on ? setpoint : 12'h000;
   end

   // APB decode; reads are captured in the setup cycle for a zero-wait answer.
   assign wr_acc   = psel & penable & pwrite;
   assign rd_setup = psel & ~penable;
   always_comb begin
      rd_val = 32'h0000_0000;
      mapped = 1'b1;
      case (paddr)
         `OFS_CTRL: begin
            rd_val[`CTRL_SRC_LSB +: 2]   = st_q.ctrl.setpoint_source_select;
            rd_val[`CTRL_DIR_BIT]        = st_q.ctrl.rotation_direction_select;
            rd_val[`CTRL_START_LSB +: 2] = st_q.ctrl.start_source_select;
            rd_val[`CTRL_CUR_BIT]        = st_q.ctrl.use_current_input;
         end
         `OFS_ENTRY: begin
            rd_val[11:0] = setpoint;
         end
         `OFS_STORED: begin
            rd_val[11:0] = st_q.stored_setpoint_freq;
         end
         `OFS_ACCEL: begin
            rd_val[14:0] = st_q.accel_ramp_time;
         end
         `OFS_DECEL: begin
            rd_val[14:0] = st_q.decel_ramp_time;
         end
         `OFS_STATUS: begin
            rd_val[11:0]           = out_freq;
            rd_val[`STAT_RUN_BIT]  = ~stopped;
            rd_val[`STAT_CCW_BIT]  = st_q.st[2];
            rd_val[`STAT_EDIT_BIT] = st_q.dirty;
         end
         `OFS_PROTECT: begin
            rd_val[0] = st_q.ctrl.parameter_write_protect;
         end
         default: begin
            mapped = 1'b0;
         end
      endcase
   end

   // Next state: synchronisers, keypad editing, register writes, run state.
   always_comb begin
      st_d    = st_q;
      st_d.s1 = panel_in;
      st_d.s2 = st_q.s1;
      st_d.s3 = st_q.s2;
      if (start_edge) begin
         st_d.kp_run = 1'b1;
      end
      if (stop_edge) begin
         st_d.kp_run = 1'b0;
      end
      // Arrow keys edit a private copy; nothing changes until enter.
      if (up_edge) begin
         st_d.edit  = clamp_freq(32'(edit_base) + 32'h0000_0001);
         st_d.dirty = 1'b1;
      end else if (down_edge) begin
         st_d.edit  = clamp_freq(32'(edit_base) - 32'h0000_0001);
         st_d.dirty = 1'b1;
      end
      if (enter_edge && st_q.dirty) begin
         if (ff_sel != 4'h0) begin
            st_d.stage[ff_sel] = st_q.edit;
         end else begin
            st_d.stored_setpoint_freq = st_q.edit;
         end
         st_d.dirty = 1'b0;
      end
      // A bus write in the same cycle as enter is the later word and wins.
      if (wr_acc) begin
         case (paddr)
            `OFS_CTRL: begin
               if (!st_q.ctrl.parameter_write_protect && stopped) begin
                  if (pwdata[`CTRL_SRC_LSB +: 2] != 2'h3) begin
                     st_d.ctrl.setpoint_source_select = pwdata[`CTRL_SRC_LSB +: 2];
                  end
                  if (pwdata[`CTRL_START_LSB +: 2] == `START_INPUTS ||
                      pwdata[`CTRL_START_LSB +: 2] == `START_KEYPAD) begin
                     st_d.ctrl.start_source_select = pwdata[`CTRL_START_LSB +: 2];
                  end
                  st_d.ctrl.rotation_direction_select = pwdata[`CTRL_DIR_BIT];
                  st_d.ctrl.use_current_input         = pwdata[`CTRL_CUR_BIT];
               end
            end
            `OFS_ENTRY: begin
               if (ff_sel != 4'h0) begin
                  st_d.stage[ff_sel] = clamp_freq(pwdata);
               end else begin
                  st_d.stored_setpoint_freq = clamp_freq(pwdata);
               end
               st_d.dirty = 1'b0;
            end
            `OFS_STORED: begin
               if (!st_q.ctrl.parameter_write_protect) begin
                  st_d.stored_setpoint_freq = clamp_freq(pwdata);
               end
            end
            `OFS_ACCEL: begin
               if (!st_q.ctrl.parameter_write_protect) begin
                  st_d.accel_ramp_time = quant_ramp(pwdata);
               end
            end
            `OFS_DECEL: begin
               if (!st_q.ctrl.parameter_write_protect) begin
                  st_d.decel_ramp_time = quant_ramp(pwdata);
               end
            end
            `OFS_PROTECT: begin
               st_d.ctrl.parameter_write_protect = pwdata[0];
            end
            default: begin
            end
         endcase
      end
      if (rd_setup) begin
         st_d.rdata  = rd_val;
         st_d.slverr = ~mapped;
      end
      // The run state leaves only once the ramp has reached zero.
      case (st_q.st)
         setpoint_pkg::ST_STOPPED: begin
            if (cw_cmd) begin
               st_d.st = setpoint_pkg::ST_RUN_CW;
            end else if (ccw_cmd) begin
               st_d.st = setpoint_pkg::ST_RUN_CCW;
            end
         end
         setpoint_pkg::ST_RUN_CW: begin
            if (!cw_cmd && out_freq == 12'h000) begin
               st_d.st = setpoint_pkg::ST_STOPPED;
            end
         end
         setpoint_pkg::ST_RUN_CCW: begin
            if (!ccw_cmd && out_freq == 12'h000) begin
               st_d.st = setpoint_pkg::ST_STOPPED;
            end
         end
         default: begin
            st_d.st = setpoint_pkg::ST_STOPPED;
         end
      endcase
   end

   // State register; fields not listed reset to zero.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q                                <= '0;
         st_q.ctrl.setpoint_source_select    <= `SRC_RESET;
         st_q.ctrl.start_source_select       <= `START_RESET;
         st_q.ctrl.rotation_direction_select <= `DIR_RESET;
         st_q.stored_setpoint_freq           <= `STORED_RESET;
         st_q.accel_ramp_time                <= `RAMP_RESET;
         st_q.decel_ramp_time                <= `RAMP_RESET;
         st_q.st                             <= setpoint_pkg::ST_STOPPED;
      end else begin
         st_q <= st_d;
      end
   end

   // Linear ramp toward the target.
   ramp_stepper #(
      .UNIT_CYCLES (RAMP_UNIT_CYCLES)
   ) u_ramp (
      .pclk      (pclk),
      .presetn   (presetn),
      .target    (target),
      .rise_time (st_q.accel_ramp_time),
      .fall_time (st_q.decel_ramp_time),
      .freq      (out_freq)
   );

   // Bus answers and drive status.
   assign pready       = psel & penable;
   assign prdata       = st_q.rdata;
   assign pslverr      = st_q.slverr;
   assign rotation_ccw = st_q.st[2];
   assign running      = ~st_q.st[0];

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence entry_read_s;
      rd_setup && !pwrite && paddr == `OFS_ENTRY;
   endsequence

   sequence edit_commit_s;
      enter_edge && st_q.dirty && !wr_acc;
   endsequence

   chk_entry_shows_setpoint: assert property (
      entry_read_s and (ff_sel == 4'h0) |=> prdata == {20'h00000, $past(base)})
      else $error("entry read does not show the setpoint");

   chk_entry_shows_stage: assert property (
      entry_read_s and (ff_sel != 4'h0) |=> prdata == {20'h00000, $past(setpoint)} && $past(setpoint) == st_q.stage[$past(ff_sel)])
      else $error("entry read does not show the fixed stage");

   chk_enter_stores_stage: assert property (
      edit_commit_s and (ff_sel != 4'h0) |=> st_q.stage[$past(ff_sel)] == $past(st_q.edit) && !st_q.dirty)
      else $error("enter did not store into the fixed stage");

   chk_enter_stores_freq: assert property (
      edit_commit_s and (ff_sel == 4'h0) |=> st_q.stored_setpoint_freq == $past(st_q.edit))
      else $error("enter did not store the setpoint");

   chk_protect_lets_entry: assert property (
      wr_acc && paddr == `OFS_ENTRY && st_q.ctrl.parameter_write_protect && ff_sel == 4'h0
      |=> st_q.stored_setpoint_freq == clamp_freq($past(pwdata)))
      else $error("protected entry write was lost");

   chk_stored_in_range: assert property (
      st_q.stored_setpoint_freq == 12'h000 ||
      (st_q.stored_setpoint_freq >= `FREQ_MIN && st_q.stored_setpoint_freq <= `FREQ_MAX))
      else $error("stored setpoint out of range");

   chk_ramp_coarse_step: assert property (
      st_q.accel_ramp_time >= `RAMP_COARSE |-> st_q.accel_ramp_time % `RAMP_COARSE_STEP == 15'h0000)
      else $error("coarse acceleration time not in whole seconds");

   chk_run_locks_select: assert property (
      !stopped ##1 !stopped |-> $stable(st_q.ctrl.setpoint_source_select) &&
      $stable(st_q.ctrl.start_source_select) && $stable(st_q.ctrl.rotation_direction_select))
      else $error("selector changed while running");

   chk_keypad_start_dir: assert property (
      stopped && st_q.ctrl.start_source_select == `START_KEYPAD && st_q.kp_run
      |=> st_q.st[2] == $past(st_q.ctrl.rotation_direction_select) && running)
      else $error("keypad start took the wrong direction");

endmodule // drive_setpoint_and_ramp_select

`default_nettype wire

// ==== hw/ramp_stepper.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "setpoint_defines.svh"

module ramp_stepper #(
   parameter int unsigned UNIT_CYCLES = `RAMP_UNIT_CYCLES
) (
   // Clock and reset.
   input  wire logic        pclk,
   input  wire logic        presetn,
   // Target and ramp times in 0.1 s.
   input  wire logic [11:0] target,
   input  wire logic [14:0] rise_time,
   input  wire logic [14:0] fall_time,
   // Output frequency in 0.1 Hz.
   output logic      [11:0] freq
);

   setpoint_pkg::ramp_state_t r_q;
   setpoint_pkg::ramp_state_t r_d;
   logic [47:0]               limit;
   logic [47:0]               acc_sum;

   // Each cycle adds the end frequency; a step is due when the sum passes
   // ramp time times the unit, so a full swing spans the ramp time exactly.
   always_comb begin
      r_d     = r_q;
      limit   = 48'(target > r_q.freq ? rise_time : fall_time) * 48'(UNIT_CYCLES);
      acc_sum = r_q.acc + 48'(`END_FREQ);
      if (target == r_q.freq) begin
         r_d.acc = '0;
      end else if (acc_sum >= limit) begin
         r_d.acc  = acc_sum - limit;
         r_d.freq = (target > r_q.freq) ? r_q.freq + 12'h001 : r_q.freq - 12'h001;
      end else begin
         r_d.acc = acc_sum;
      end
   end

   // State register.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r_q <= '0;
      end else begin
         r_q <= r_d;
      end
   end

   assign freq = r_q.freq;

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   chk_ramp_one_step: assert property (
      $past(target) > $past(r_q.freq) |-> r_q.freq == $past(r_q.freq) || r_q.freq == $past(r_q.freq) + 12'h001)
      else $error("ramp moved by more than one step upward");

   chk_ramp_fall_dir: assert property (
      target < r_q.freq |=> r_q.freq <= $past(r_q.freq))
      else $error("ramp rose while target lies below");

endmodule // ramp_stepper

`default_nettype wire

// ==== hw/setpoint_defines.svh ====
`ifndef SETPOINT_DEFINES_SVH
`define SETPOINT_DEFINES_SVH

// Register byte offsets on the APB port.
`define OFS_CTRL          8'h00
`define OFS_ENTRY         8'h04
`define OFS_STORED        8'h08
`define OFS_ACCEL         8'h0C
`define OFS_DECEL         8'h10
`define OFS_STATUS        8'h14
`define OFS_PROTECT       8'h18

// Control and status field positions.
`define CTRL_SRC_LSB      0
`define CTRL_DIR_BIT      2
`define CTRL_START_LSB    3
`define CTRL_CUR_BIT      5
`define STAT_RUN_BIT      16
`define STAT_CCW_BIT      17
`define STAT_EDIT_BIT     18

// Selector encodings.
`define SRC_POT           2'h0
`define SRC_ANALOG        2'h1
`define SRC_STORED        2'h2
`define START_INPUTS      2'h1
`define START_KEYPAD      2'h2
`define DIR_CW            1'h0

// Reset values; frequencies in 0.1 Hz, ramp times in 0.1 s.
`define SRC_RESET         2'h1
`define START_RESET       2'h1
`define DIR_RESET         1'h0
`define STORED_RESET      12'h000
`define RAMP_RESET        15'h0064

// Value limits.
`define FREQ_MIN          12'h005
`define FREQ_MAX          12'hE10
`define END_FREQ          12'hE10
`define RAMP_MIN          15'h0001
`define RAMP_MAX          15'h7530
`define RAMP_COARSE       15'h2710
`define RAMP_COARSE_STEP  15'h000A

// Timing: one ramp time unit is 0.1 s.
`define CLK_PERIOD_NS     5
`define RAMP_UNIT_NS      100000000
`define RAMP_UNIT_CYCLES  (`RAMP_UNIT_NS / `CLK_PERIOD_NS)

`endif

// ==== hw/setpoint_pkg.sv ====
package setpoint_pkg;

   // Run state of the drive, one-hot.
   typedef enum logic [2:0] {
      ST_STOPPED = 3'h1,
      ST_RUN_CW  = 3'h2,
      ST_RUN_CCW = 3'h4
   } run_state_t;

   // Operator panel and digital control pins.
   typedef struct packed {
      logic        key_up;
      logic        key_down;
      logic        key_enter;
      logic        key_start;
      logic        key_stop;
      logic        run_forward_input;
      logic        run_reverse_input;
      logic [3:0]  fixed_freq_stage_select;
      logic [11:0] keypad_pot_input;
      logic [11:0] voltage_setpoint_input;
      logic [11:0] current_setpoint_input;
   } panel_t;

   // Software control fields.
   typedef struct packed {
      logic [1:0] setpoint_source_select;
      logic       rotation_direction_select;
      logic [1:0] start_source_select;
      logic       use_current_input;
      logic       parameter_write_protect;
   } ctrl_t;

   // Whole state of the main block.
   typedef struct packed {
      ctrl_t             ctrl;
      logic [11:0]       stored_setpoint_freq;
      logic [11:0]       edit;
      logic              dirty;
      logic              kp_run;
      logic [14:0]       accel_ramp_time;
      logic [14:0]       decel_ramp_time;
      run_state_t        st;
      logic [15:0][11:0] stage;
      panel_t            s1;
      panel_t            s2;
      panel_t            s3;
      logic [31:0]       rdata;
      logic              slverr;
   } main_state_t;

   // Whole state of the ramp generator.
   typedef struct packed {
      logic [11:0] freq;
      logic [47:0] acc;
   } ramp_state_t;

endpackage

// ==== test/panel_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module panel_model (
   // Clock.
   input  wire logic                pclk,
   // Keypad and control pins toward the block.
   output var setpoint_pkg::panel_t panel_out
);
   // All pins idle low until the bench sets levels.
   initial begin
      panel_out = '0;
   end

   // One press of the keys in mask {up, down, enter, start, stop}: held past the synchronisers,
   // then low long enough that the next press is a fresh edge.
   task automatic press(input logic [4:0] mask);
      @(posedge pclk);
      {panel_out.key_up, panel_out.key_down, panel_out.key_enter, panel_out.key_start, panel_out.key_stop} <= mask;
      repeat (4) @(posedge pclk);
      {panel_out.key_up, panel_out.key_down, panel_out.key_enter, panel_out.key_start, panel_out.key_stop} <= 5'h00;
      repeat (5) @(posedge pclk);
   endtask
endmodule // panel_model
`default_nettype wire

// ==== test/tb_drive_setpoint_and_ramp_select.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "setpoint_defines.svh"
module tb_drive_setpoint_and_ramp_select;
   logic                 pclk;
   logic                 presetn;
   logic                 psel;
   logic                 penable;
   logic                 pwrite;
   logic [7:0]           paddr;
   logic [31:0]          pwdata;
   logic [31:0]          prdata;
   logic                 pready;
   logic                 pslverr;
   setpoint_pkg::panel_t panel_in;
   logic [11:0]          out_freq;
   logic                 rotation_ccw;
   logic                 running;
   int                   failures;
   int                   cmp_count;
   logic [31:0]          rv;
   logic                 re;

   // A short ramp unit keeps a full ramp within a few thousand cycles.
   drive_setpoint_and_ramp_select #(.RAMP_UNIT_CYCLES(10)) drive_setpoint_and_ramp_select_i (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .panel_in(panel_in), .out_freq(out_freq), .rotation_ccw(rotation_ccw), .running(running)
   );
   panel_model panel_model_i (.pclk(pclk), .panel_out(panel_in));

   // Clock at 200 MHz.
   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end

   // Comparison with counting.
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
      end
   endtask

   // One APB transfer; the request stands until pready is seen high at a rising edge.
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      // Only the watchdog ends this wait; the slave sets its own pace.
      while (pready !== 1'b1) @(posedge pclk);
      rv = prdata;
      re = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h00000000);
      chk(rv, exp);
   endtask

   // Reset values and an unmapped address.
   task automatic t_reset();
      rd(`OFS_CTRL, 32'h00000009);
      rd(`OFS_STORED, 32'h00000000);
      rd(`OFS_ACCEL, 32'h00000064);
      rd(`OFS_DECEL, 32'h00000064);
      rd(8'h1C, 32'h00000000);
      chk(re, 1'b1);
   endtask

   // Every source choice shows through the entry value in one format.
   task automatic t_source();
      logic [31:0] ctl[4] = '{32'h08, 32'h09, 32'h29, 32'h0A};
      logic [31:0] exp[4] = '{32'h111, 32'h222, 32'h333, 32'h123};
      panel_model_i.panel_out.keypad_pot_input <= 12'h111;
      panel_model_i.panel_out.voltage_setpoint_input <= 12'h222;
      panel_model_i.panel_out.current_setpoint_input <= 12'h333;
      wr(`OFS_STORED, 32'h00000123);
      for (int i = 0; i < 4; i++) begin
         wr(`OFS_CTRL, ctl[i]);
         rd(`OFS_ENTRY, exp[i]);
      end
      wr(`OFS_PROTECT, 32'h00000001);
      wr(`OFS_STORED, 32'h00000050);
      rd(`OFS_STORED, 32'h00000123);
      wr(`OFS_ENTRY, 32'h000000AB);
      rd(`OFS_STORED, 32'h000000AB);
      wr(`OFS_PROTECT, 32'h00000000);
   endtask

   // Arrow edit and enter land in the stored setpoint; enter alone changes nothing.
   task automatic t_keys();
      panel_model_i.press(5'h10);
      panel_model_i.press(5'h04);
      rd(`OFS_STORED, 32'h000000AC);
      // Two down presses chain on the pending edit before enter commits it.
      panel_model_i.press(5'h08);
      panel_model_i.press(5'h08);
      panel_model_i.press(5'h04);
      rd(`OFS_STORED, 32'h000000AA);
      panel_model_i.press(5'h04);
      rd(`OFS_STORED, 32'h000000AA);
   endtask

   // Fixed stage selected: entry shows and stores the stage, not the setpoint.
   task automatic t_stage();
      panel_model_i.panel_out.fixed_freq_stage_select <= 4'h3;
      repeat (4) @(posedge pclk);
      rd(`OFS_ENTRY, 32'h00000000);
      wr(`OFS_ENTRY, 32'h00000200);
      panel_model_i.press(5'h10);
      panel_model_i.press(5'h04);
      rd(`OFS_ENTRY, 32'h00000201);
      panel_model_i.panel_out.fixed_freq_stage_select <= 4'h0;
      repeat (4) @(posedge pclk);
      rd(`OFS_ENTRY, 32'h000000AA);
   endtask

   // Ramp time steps and limits.
   task automatic t_ramp_cfg();
      logic [31:0] wv[4] = '{32'h2715, 32'h3E7, 32'h0, 32'h9C40};
      logic [31:0] ev[4] = '{32'h2710, 32'h3E7, 32'h1, 32'h7530};
      for (int i = 0; i < 4; i++) begin
         wr(`OFS_ACCEL, wv[i]);
         rd(`OFS_ACCEL, ev[i]);
      end
   endtask

   // Run from the inputs, then from the keypad anticlockwise.
   task automatic t_run();
      int n;
      wr(`OFS_ACCEL, 32'h000002D0);
      wr(`OFS_DECEL, 32'h00000168);
      wr(`OFS_STORED, 32'h00000014);
      panel_model_i.panel_out.run_forward_input <= 1'b1;
      for (n = 0; n < 20 && running !== 1'b1; n++) @(posedge pclk);
      chk(running, 1'b1);
      for (n = 0; n < 100 && out_freq !== 12'h014; n++) @(posedge pclk);
      chk(n >= 36 && n <= 44, 1'b1);
      chk(rotation_ccw, 1'b0);
      rd(`OFS_STATUS, 32'h00010014);
      wr(`OFS_CTRL, 32'h0000000D);
      rd(`OFS_CTRL, 32'h0000000A);
      wr(`OFS_STORED, 32'h0000000A);
      for (n = 0; n < 100 && out_freq !== 12'h00A; n++) @(posedge pclk);
      chk(out_freq, 12'h00A);
      panel_model_i.panel_out.run_forward_input <= 1'b0;
      for (n = 0; n < 100 && out_freq !== 12'h000; n++) @(posedge pclk);
      chk(n >= 9 && n <= 15, 1'b1);
      repeat (3) @(posedge pclk);
      chk(running, 1'b0);
      wr(`OFS_CTRL, 32'h00000016);
      panel_model_i.press(5'h02);
      chk(running & rotation_ccw, 1'b1);
      panel_model_i.press(5'h01);
      for (n = 0; n < 200 && running !== 1'b0; n++) @(posedge pclk);
      chk(running, 1'b0);
      // Back to the run inputs: both at once is no command, reverse alone runs anticlockwise.
      wr(`OFS_CTRL, 32'h0000000A);
      panel_model_i.panel_out.run_forward_input <= 1'b1;
      panel_model_i.panel_out.run_reverse_input <= 1'b1;
      repeat (8) @(posedge pclk);
      chk(running, 1'b0);
      panel_model_i.panel_out.run_forward_input <= 1'b0;
      for (n = 0; n < 20 && running !== 1'b1; n++) @(posedge pclk);
      chk(running & rotation_ccw, 1'b1);
      panel_model_i.panel_out.run_reverse_input <= 1'b0;
      for (n = 0; n < 200 && running !== 1'b0; n++) @(posedge pclk);
      chk(running, 1'b0);
   endtask

   // Verdict and end of run.
   task automatic summarize();
      if (failures == 0 && cmp_count > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   // Main sequence after five cycles of reset.
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h00000000;
      failures = 0;
      cmp_count = 0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_source();
      t_keys();
      t_stage();
      t_ramp_cfg();
      t_run();
      summarize();
   end

   // Watchdog at 20000 cycles, well beyond the expected few hundred cycles.
   initial begin
      #100000;
      failures++;
      summarize();
   end
endmodule // tb_drive_setpoint_and_ramp_select
`default_nettype wire
